/* verilog/sscs_top.sv */
// Start/stop sequencer, contact decoding and relay drive of a soft
// starter. Assumes a ramp engine that reports end of ramp, current
// drop and stop level, and protection logic that reports trips.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - Ramp contact closed selects second ramp set
// - Open ramp contact uses first ramp set
// - Zero time and 600% gives across-line start
// - Ramp input defaults to external reset, reassignable
// - Jog input defaults to normally-closed lockout
// - Jog input assignable: jog, remote, NO/NC lockout
// - Jog only runs with a start command
// - Lockout trips at once, code by phase
// - Lockout cuts power even during deceleration
// - Fault output fixed to any trip
// - Relay one: run, drops on stop or decel
// - Relay two: at-speed, drops on stop
// - At-speed on current drop or 30 s
// - Relay three closes on trips 5 to 21
// - Each relay function programmable independently
// - Motor stays off until a start command
// - At speed lights indicator and closes bypass
// - Stop without decel: all off, coast
// - Stop with decel: bypass opens, decel, off
// - Jog input alters serial control per mode
module sscs_top #(
  parameter int AT_SPEED_CYC = sscs_pkg::AT_SPEED_CYC,
  parameter int DB_CYC = sscs_pkg::DEBOUNCE_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic run_contact_i,
  input wire logic ramp_contact_i,
  input wire logic jog_contact_i,
  input wire logic ramp_end_i,
  input wire logic current_drop_i,
  input wire logic stop_level_i,
  input wire logic fault_valid_i,
  input wire logic [4:0] fault_code_i,
  output logic motor_on_o,
  output logic bypass_o,
  output logic at_speed_o,
  output logic decel_active_o,
  output logic jog_active_o,
  output logic ramp_set_o,
  output logic [7:0] ramp_time_o,
  output logic [9:0] ramp_ilim_o,
  output logic serial_ctrl_o,
  output logic fault_o,
  output logic [4:0] trip_code_o,
  output logic [2:0] aux_o
);
  // ****************************************************************
  // Contact inputs
  // ****************************************************************
  logic [2:0] raw_w; // Run, ramp, jog contacts
  logic [2:0] db_w; // Debounced levels
  assign raw_w = {jog_contact_i, ramp_contact_i, run_contact_i};

  // One debouncer per contact
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_db
      sscs_debounce #(.DB_CYC(DB_CYC), .CNT_W(18)) u_db (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .raw_i(raw_w[gi]),
        .clean_o(db_w[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic decel_en_r; // decel_enable_setting
  logic sw_run_r; // Run command over the serial link
  logic [3:0] ifs_r; // input_function_select
  logic [1:0] ccm_r; // comm_control_mode
  logic [4:0] fn_r [3]; // relay_one..three_function
  logic [7:0] rt_r [2]; // Ramp times, first and second set
  logic [9:0] ri_r [2]; // Current limits, first and second set
  logic wait_r; // Registered waitrequest
  logic ramp_prev_r; // Ramp contact, last cycle
  logic [31:0] rd_w; // Read mux output

  // Bus decode
  wire req_w = avs_read_i | avs_write_i;
  wire wr_w = avs_write_i & ~wait_r; // Write takes effect here
  wire sel_ctrl = avs_address_i == sscs_pkg::OFS_CTRL;
  wire sel_rly = avs_address_i == sscs_pkg::OFS_RELAY;
  wire sel_r1 = avs_address_i == sscs_pkg::OFS_RAMP1;
  wire sel_r2 = avs_address_i == sscs_pkg::OFS_RAMP2;
  wire sel_st = avs_address_i == sscs_pkg::OFS_STATUS;
  wire [31:0] wd = avs_writedata_i;
  wire sw_clear = wr_w & sel_ctrl & wd[sscs_pkg::CTL_CLEAR];

  // ****************************************************************
  // Input functions
  // ****************************************************************
  wire run_db = db_w[0];
  wire ramp_db = db_w[1];
  wire jog_db = db_w[2];
  wire [1:0] rin_fn = ifs_r[1:0];
  wire [1:0] jin_fn = ifs_r[3:2];
  wire lockout_w = ((jin_fn == sscs_pkg::JIN_LOCK_NC) & ~jog_db)
    | ((jin_fn == sscs_pkg::JIN_LOCK_NO) & jog_db);
  wire jog_sel_w = (jin_fn == sscs_pkg::JIN_JOG) & jog_db;
  wire remote_w = ((jin_fn == sscs_pkg::JIN_REMOTE) & jog_db)
    | (ccm_r == sscs_pkg::CCM_ALWAYS)
    | ((ccm_r == sscs_pkg::CCM_JOG) & jog_db);
  wire run_cmd = remote_w ? sw_run_r : run_db;
  wire ramp_sel_w = (rin_fn == sscs_pkg::RIN_RAMP_SEL) & ramp_db;
  wire ramp_rise = ramp_db & ~ramp_prev_r;
  // Remote reset only counts while serial control is selected
  wire ext_reset = ramp_rise & ((rin_fn == sscs_pkg::RIN_EXT_RESET)
    | ((rin_fn == sscs_pkg::RIN_REM_RESET) & remote_w));
  wire [7:0] sel_time = rt_r[ramp_sel_w];
  wire [9:0] sel_ilim = ri_r[ramp_sel_w];
  wire atl_w = (sel_time == 8'h00)
    & (sel_ilim == sscs_pkg::ILIM_ATL);

  // Avalon slave: one wait cycle, then the answer
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req_w & wait_r);
    end
  end

  // Control register writes
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      decel_en_r <= 1'b0;
      sw_run_r <= 1'b0;
      ifs_r <= sscs_pkg::IFS_RESET;
      ccm_r <= sscs_pkg::CCM_OFF;
    end else if (wr_w & sel_ctrl) begin
      decel_en_r <= wd[sscs_pkg::CTL_DECEL];
      sw_run_r <= wd[sscs_pkg::CTL_SWRUN];
      ifs_r <= wd[sscs_pkg::CTL_IFS_LO +: 4];
      ccm_r <= wd[sscs_pkg::CTL_CCM_LO +: 2];
    end
  end

  // Relay functions and ramp sets, one entry each
  generate
    for (gi = 0; gi < 3; gi++) begin : g_fn
      localparam logic [4:0] FN_DEF = (gi == 0) ? sscs_pkg::FN_RUN
        : (gi == 1) ? sscs_pkg::FN_AT_SPEED : sscs_pkg::FN_TRIP_RANGE;
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          fn_r[gi] <= FN_DEF;
        end else if (wr_w & sel_rly) begin
          fn_r[gi] <= wd[gi*sscs_pkg::RLY_STRIDE +: 5];
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_ramp
      wire sel_w = (gi == 0) ? sel_r1 : sel_r2;
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          rt_r[gi] <= sscs_pkg::RAMP_TIME_RST;
          ri_r[gi] <= sscs_pkg::RAMP_ILIM_RST;
        end else if (wr_w & sel_w) begin
          rt_r[gi] <= wd[7:0];
          ri_r[gi] <= wd[sscs_pkg::RMP_ILIM_LO +: 10];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  sscs_pkg::sscs_state_e state_r, state_nxt; // Operating phase
  logic [29:0] spd_cnt_r; // Cycles since start
  logic ramp_end_r; // End of ramp seen this start
  logic jog_r; // This run is a jog
  logic [4:0] code_nxt; // Trip code to hold
  logic [4:0] lock_code; // Lockout code of current phase
  wire spd_timeout = spd_cnt_r == 30'(AT_SPEED_CYC - 1);
  wire at_speed_hit = (ramp_end_r & current_drop_i) | spd_timeout;
  wire trip_w = state_r != sscs_pkg::ST_TRIP
    & (lockout_w | fault_valid_i);

  // Lockout code follows the phase at the trip
  assign lock_code = (state_r == sscs_pkg::ST_RUN) ? sscs_pkg::LOCK_RUN
    : (state_r == sscs_pkg::ST_DECEL) ? sscs_pkg::LOCK_DECEL
    : sscs_pkg::LOCK_ACCEL;

  // Next phase; trips take priority over every command
  always_comb begin
    state_nxt = state_r;
    code_nxt = trip_code_o;
    if (trip_w) begin
      state_nxt = sscs_pkg::ST_TRIP;
      code_nxt = lockout_w ? lock_code : fault_code_i;
    end else begin
      case (state_r)
        sscs_pkg::ST_IDLE: begin
          // Jog alone never starts; run command is needed
          if (run_cmd) begin
            state_nxt = atl_w ? sscs_pkg::ST_RUN : sscs_pkg::ST_ACCEL;
          end
        end
        sscs_pkg::ST_ACCEL, sscs_pkg::ST_RUN: begin
          if (!run_cmd) begin
            state_nxt = decel_en_r ? sscs_pkg::ST_DECEL
              : sscs_pkg::ST_IDLE;
          end else if (state_r == sscs_pkg::ST_ACCEL && at_speed_hit) begin
            state_nxt = sscs_pkg::ST_RUN;
          end
        end
        sscs_pkg::ST_DECEL: begin
          if (stop_level_i) begin
            state_nxt = sscs_pkg::ST_IDLE;
          end
        end
        sscs_pkg::ST_TRIP: begin
          if (sw_clear | ext_reset) begin
            state_nxt = sscs_pkg::ST_IDLE;
            code_nxt = 5'h00;
          end
        end
        default: state_nxt = sscs_pkg::ST_IDLE;
      endcase
    end
  end

  // Phase, trip code and at-speed timer
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state_r <= sscs_pkg::ST_IDLE;
      trip_code_o <= 5'h00;
      spd_cnt_r <= '0;
      ramp_end_r <= 1'b0;
      ramp_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      trip_code_o <= code_nxt;
      ramp_prev_r <= ramp_db;
      // Timer and ramp end restart with every acceleration
      if (state_r != sscs_pkg::ST_ACCEL) begin
        spd_cnt_r <= '0;
        ramp_end_r <= 1'b0;
      end else begin
        spd_cnt_r <= spd_cnt_r + 1'b1;
        ramp_end_r <= ramp_end_r | ramp_end_i;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire going = state_nxt inside {sscs_pkg::ST_ACCEL, sscs_pkg::ST_RUN};
  wire in_run = state_nxt == sscs_pkg::ST_RUN;
  wire in_trip = state_nxt == sscs_pkg::ST_TRIP;
  wire trip_rng = in_trip & (code_nxt >= sscs_pkg::TRIP_LO)
    & (code_nxt <= sscs_pkg::TRIP_HI);

  // Relay state for one function code
  function automatic logic relay_eval(input logic [4:0] fn);
    case (fn)
      sscs_pkg::FN_RUN: relay_eval = going;
      sscs_pkg::FN_AT_SPEED: relay_eval = in_run;
      sscs_pkg::FN_TRIP_RANGE: relay_eval = trip_rng;
      sscs_pkg::FN_ANY_TRIP: relay_eval = in_trip;
      default: relay_eval = 1'b0;
    endcase
  endfunction

  // Registered drive of power stage, relays and indicators
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      motor_on_o <= 1'b0;
      bypass_o <= 1'b0;
      at_speed_o <= 1'b0;
      decel_active_o <= 1'b0;
      jog_r <= 1'b0;
      ramp_set_o <= 1'b0;
      fault_o <= 1'b0;
      aux_o <= 3'h0;
    end else begin
      motor_on_o <= going | (state_nxt == sscs_pkg::ST_DECEL);
      bypass_o <= in_run;
      at_speed_o <= in_run;
      decel_active_o <= state_nxt == sscs_pkg::ST_DECEL;
      if (state_r == sscs_pkg::ST_IDLE) begin
        jog_r <= jog_sel_w;
      end
      ramp_set_o <= ramp_sel_w;
      fault_o <= relay_eval(sscs_pkg::FN_ANY_TRIP);
      for (int i = 0; i < 3; i++) begin
        aux_o[i] <= relay_eval(fn_r[i]);
      end
    end
  end

  // Selected ramp set, serial control flag, jog and bus answer
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ramp_time_o <= sscs_pkg::RAMP_TIME_RST;
      ramp_ilim_o <= sscs_pkg::RAMP_ILIM_RST;
      serial_ctrl_o <= 1'b0;
      jog_active_o <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ramp_time_o <= sel_time;
      ramp_ilim_o <= sel_ilim;
      serial_ctrl_o <= remote_w;
      jog_active_o <= jog_r & going;
      if (avs_read_i & wait_r) begin
        avs_readdata_o <= rd_w;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_w = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_w = {22'h0, ccm_r, ifs_r, 2'h0, sw_run_r, decel_en_r};
    end else if (sel_rly) begin
      rd_w = {11'h0, fn_r[2], 3'h0, fn_r[1], 3'h0, fn_r[0]};
    end else if (sel_r1 | sel_r2) begin
      rd_w = {6'h0, ri_r[sel_r2], 8'h0, rt_r[sel_r2]};
    end else if (sel_st) begin
      rd_w = {18'h0, db_w, trip_code_o, ramp_set_o, at_speed_o,
        bypass_o, state_r};
    end
  end
  assign avs_waitrequest_o = wait_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic live_r;
  // Attempts wait one edge past reset release
  always_ff @(posedge clock_i) begin
    live_r <= nrst_i;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i || !live_r);
  sequence s_run_stop;
    state_r == sscs_pkg::ST_RUN && !run_cmd && !trip_w;
  endsequence
  sequence s_decel_hold;
    motor_on_o && !bypass_o && decel_active_o;
  endsequence
  a_ramp_second: assert property (ramp_sel_w |=> ramp_set_o)
    else $error("second ramp set not selected");
  a_ramp_first: assert property (!ramp_sel_w |=> !ramp_set_o)
    else $error("first ramp set not selected");
  a_across_line: assert property (state_r == sscs_pkg::ST_IDLE
    && run_cmd && atl_w && !trip_w |=> bypass_o && motor_on_o)
    else $error("across-line start missing");
  a_lock_trip: assert property (lockout_w && trip_w
    |=> state_r == sscs_pkg::ST_TRIP && trip_code_o == $past(lock_code)
    && fault_o && !motor_on_o)
    else $error("lockout trip wrong");
  a_lock_decel: assert property (state_r == sscs_pkg::ST_DECEL
    && lockout_w |=> !motor_on_o && !decel_active_o)
    else $error("lockout left power on in decel");
  a_fault_any: assert property (fault_valid_i && trip_w
    |=> fault_o && trip_code_o == $past(fault_code_i))
    else $error("fault output missed a trip");
  a_relay_run: assert property (fn_r[0] == sscs_pkg::FN_RUN
    && state_r == sscs_pkg::ST_DECEL |-> !aux_o[0])
    else $error("relay one held during decel");
  a_speed_time: assert property (spd_timeout
    && state_r == sscs_pkg::ST_ACCEL && run_cmd && !trip_w
    |=> at_speed_o && bypass_o)
    else $error("forced at-speed missed");
  a_jog_start: assert property (state_r == sscs_pkg::ST_IDLE
    && !run_cmd |=> !motor_on_o)
    else $error("motor started without command");
  a_stop_coast: assert property (s_run_stop ##0 !decel_en_r
    |=> !motor_on_o && !bypass_o && !at_speed_o)
    else $error("coast stop wrong");
  a_stop_decel: assert property (s_run_stop ##0 decel_en_r
    |=> s_decel_hold)
    else $error("controlled stop wrong");
endmodule

/* verilog/sscs_pkg.sv */
// Constants and types of the soft starter control sequencer.
// Assumes a single 20 MHz clock and a 32-bit Avalon-MM register slave.
package sscs_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 20000000; // Core clock rate
  localparam int AT_SPEED_MS = 30000; // Forced at-speed after start
  localparam int AT_SPEED_CYC = AT_SPEED_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_US = 10000; // Contact settle time
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [5:0] OFS_CTRL = 6'h00; // Control bits
  localparam logic [5:0] OFS_RELAY = 6'h04; // Relay functions
  localparam logic [5:0] OFS_RAMP1 = 6'h08; // First ramp set
  localparam logic [5:0] OFS_RAMP2 = 6'h0c; // Second ramp set
  localparam logic [5:0] OFS_STATUS = 6'h10; // Read-only state
  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int CTL_DECEL = 0; // decel_enable_setting
  localparam int CTL_SWRUN = 1; // Serial run command
  localparam int CTL_CLEAR = 2; // Write 1 clears a trip
  localparam int CTL_IFS_LO = 4; // input_function_select
  localparam int CTL_CCM_LO = 8; // comm_control_mode
  localparam int RLY_STRIDE = 8; // One byte per relay function
  localparam int RMP_ILIM_LO = 16; // Current limit in ramp word
  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [3:0] IFS_RESET = 4'h0; // Reset input, NC lockout
  localparam logic [1:0] RIN_EXT_RESET = 2'h0; // Ramp input functions
  localparam logic [1:0] RIN_REM_RESET = 2'h1;
  localparam logic [1:0] RIN_RAMP_SEL = 2'h2;
  localparam logic [1:0] JIN_LOCK_NC = 2'h0; // Jog input functions
  localparam logic [1:0] JIN_LOCK_NO = 2'h1;
  localparam logic [1:0] JIN_JOG = 2'h2;
  localparam logic [1:0] JIN_REMOTE = 2'h3;
  localparam logic [1:0] CCM_OFF = 2'h0; // Serial control modes
  localparam logic [1:0] CCM_ALWAYS = 2'h1;
  localparam logic [1:0] CCM_JOG = 2'h2;
  localparam logic [4:0] FN_OFF = 5'h00; // Relay function codes
  localparam logic [4:0] FN_RUN = 5'h01;
  localparam logic [4:0] FN_AT_SPEED = 5'h02;
  localparam logic [4:0] FN_TRIP_RANGE = 5'h03;
  localparam logic [4:0] FN_ANY_TRIP = 5'h16;
  localparam logic [4:0] TRIP_LO = 5'h05; // Range for FN_TRIP_RANGE
  localparam logic [4:0] TRIP_HI = 5'h15;
  localparam logic [4:0] LOCK_ACCEL = 5'h08; // Lockout codes by phase
  localparam logic [4:0] LOCK_RUN = 5'h09;
  localparam logic [4:0] LOCK_DECEL = 5'h0a;
  localparam logic [7:0] RAMP_TIME_RST = 8'h0a; // Seconds
  localparam logic [9:0] RAMP_ILIM_RST = 10'h15e; // Percent
  localparam logic [9:0] ILIM_ATL = 10'h258; // 600 percent
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACCEL, ST_RUN, ST_DECEL, ST_TRIP
  } sscs_state_e;
endpackage

/* verilog/sscs_debounce.sv */
// Synchroniser and debouncer for one dry contact input.
// Assumes the raw contact level may change at any time.
`timescale 1ns/1ps
module sscs_debounce #(
  parameter int DB_CYC = 200000,
  parameter int CNT_W = 18
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic raw_i,
  output logic clean_o
);
  logic meta_r; // First stage, read only by sync_r
  logic sync_r; // Second stage
  logic [CNT_W-1:0] cnt_r; // Cycles the new level has held
  wire differs = sync_r != clean_o;
  wire settled = cnt_r == CNT_W'(DB_CYC - 1);

  // Two-flop synchroniser
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= raw_i;
      sync_r <= meta_r;
    end
  end

  // Accept a new level only after it held for DB_CYC cycles
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      clean_o <= 1'b0;
    end else if (!differs) begin
      cnt_r <= '0;
    end else if (settled) begin
      cnt_r <= '0;
      clean_o <= sync_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

/* testbench/sscs_plant.sv */
// Plant model: ramp engine and current sense beside the sequencer.
// Assumes motor_on_i and bypass_i come straight from the sequencer.
`timescale 1ns/1ps
module sscs_plant (
  input wire logic clock_i,
  input wire logic motor_on_i,
  input wire logic bypass_i,
  input wire logic drop_en_i,
  input wire logic stop_en_i,
  output logic ramp_end_o,
  output logic current_drop_o,
  output logic stop_level_o
);
  int ramp_cnt = 0; // Cycles of powered ramping
  // Counts only while ramping, so a restart begins a fresh ramp
  always @(posedge clock_i) begin
    ramp_cnt <= (motor_on_i && !bypass_i) ? ramp_cnt + 1 : 0;
  end
  // Current falls two cycles after the ramp ends, unless withheld
  assign ramp_end_o = ramp_cnt >= 10;
  assign current_drop_o = drop_en_i && ramp_cnt >= 12;
  assign stop_level_o = stop_en_i && motor_on_i; // Decel floor reached
endmodule

/* testbench/sscs_top_test.sv */
// Self-checking bench of the soft starter sequencer.
// Assumes shortened counts: debounce 4 cycles, forced at-speed 50.
`timescale 1ns/1ps
module sscs_top_test;
  localparam int DB = 4; // Debounce cycles
  localparam int ATS = 50; // Forced at-speed cycles
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0; // Active low
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic run_contact_i = 1'b0;
  logic ramp_contact_i = 1'b0;
  logic jog_contact_i = 1'b1; // Lockout loop closed
  logic fault_valid_i = 1'b0;
  logic [4:0] fault_code_i = 5'h00;
  logic drop_en = 1'b1;
  logic stop_en = 1'b0;
  logic ramp_end_i, current_drop_i, stop_level_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, motor_on_o, bypass_o, at_speed_o;
  logic decel_active_o, jog_active_o, ramp_set_o, serial_ctrl_o, fault_o;
  logic [7:0] ramp_time_o;
  logic [9:0] ramp_ilim_o;
  logic [4:0] trip_code_o;
  logic [2:0] aux_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  int codes[$];
  logic [31:0] q;
  logic [31:0] ctrl = 32'h0;
  logic [31:0] fns = 32'h00030201; // Model of relay functions
  logic [31:0] lfsr = 32'h21fb30b7;
  sscs_top #(.AT_SPEED_CYC(ATS), .DB_CYC(DB)) i_sscs_top (.clock_i,
    .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .run_contact_i, .ramp_contact_i,
    .jog_contact_i, .ramp_end_i, .current_drop_i, .stop_level_i,
    .fault_valid_i, .fault_code_i, .motor_on_o, .bypass_o, .at_speed_o,
    .decel_active_o, .jog_active_o, .ramp_set_o, .ramp_time_o,
    .ramp_ilim_o, .serial_ctrl_o, .fault_o, .trip_code_o, .aux_o);
  sscs_plant i_sscs_plant (.clock_i, .motor_on_i(motor_on_o),
    .bypass_i(bypass_o), .drop_en_i(drop_en), .stop_en_i(stop_en),
    .ramp_end_o(ramp_end_i), .current_drop_o(current_drop_i),
    .stop_level_o(stop_level_i));
  // ****************************************************************
  // Clock, hang guard and helpers
  // ****************************************************************
  always #25 clock_i = ~clock_i;
  // A hang counts as a mismatch and ends the run
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task stop_test();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // LFSR step
  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task tick(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task settle(); // Contact change plus debounce and sync
    tick(DB + 6);
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task wait_speed();
    for (n = 0; n < 200 && at_speed_o !== 1'b1; n++) tick(1);
  endtask
  // Relay model: each byte holds one relay's function code
  function automatic logic [31:0] relays(input logic trip, input int c,
      input logic run, input logic spd);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 3; i++) begin
      case (fns[8*i +: 5])
        sscs_pkg::FN_RUN: r[i] = run;
        sscs_pkg::FN_AT_SPEED: r[i] = spd;
        sscs_pkg::FN_TRIP_RANGE: r[i] = trip && c >= 5 && c <= 21;
        sscs_pkg::FN_ANY_TRIP: r[i] = trip;
        default: r[i] = 1'b0;
      endcase
    end
    return r;
  endfunction
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    tick(3);
    chk(32'({avs_waitrequest_o, motor_on_o, fault_o}), 32'h4);
    chk(32'({ramp_time_o, ramp_ilim_o}), 32'h0295e);
    nrst_i <= 1'b1;
    settle();
    bus(1'b1, sscs_pkg::OFS_CTRL, 32'h4); // Drop any start-up trip
    bus(1'b0, sscs_pkg::OFS_RELAY, 32'h0);
    chk(q, 32'h00030201);
    bus(1'b0, sscs_pkg::OFS_RAMP1, 32'h0);
    chk(q, 32'h015e000a);
    bus(1'b0, 6'h14, 32'h0); // Unmapped reads zero
    chk(q, 32'h0);
    bus(1'b1, sscs_pkg::OFS_STATUS, 32'hffffffff);
    bus(1'b0, sscs_pkg::OFS_STATUS, 32'h0);
    chk(32'({q[2:0], fault_o}), 32'h0);
    // Short run blip must be filtered out
    run_contact_i <= 1'b1;
    tick(2);
    run_contact_i <= 1'b0;
    settle();
    chk(32'(motor_on_o), 32'h0);
    // Normal start on the first set, coast stop
    bus(1'b1, sscs_pkg::OFS_RAMP1, 32'h00c80005);
    run_contact_i <= 1'b1;
    settle();
    chk(32'({motor_on_o, ramp_set_o, at_speed_o}), 32'h4);
    chk(32'({ramp_time_o, ramp_ilim_o}), 32'h014c8);
    chk(32'(aux_o), relays(0, 0, 1, 0));
    wait_speed();
    chk(32'({bypass_o, at_speed_o}), 32'h3);
    chk(32'(aux_o), relays(0, 0, 1, 1));
    run_contact_i <= 1'b0;
    settle();
    chk(32'({motor_on_o, bypass_o, at_speed_o, aux_o}), 32'h0);
    // No current drop: forced at-speed
    drop_en <= 1'b0;
    run_contact_i <= 1'b1;
    for (n = 0; n < 100 && motor_on_o !== 1'b1; n++) tick(1);
    wait_speed();
    chk(32'(n >= ATS - 3 && n <= ATS + 2), 32'h1);
    run_contact_i <= 1'b0;
    drop_en <= 1'b1;
    settle();
    // Second set, across-line, then decel and lockout in decel
    ctrl = 32'h21;
    bus(1'b1, sscs_pkg::OFS_CTRL, ctrl);
    bus(1'b1, sscs_pkg::OFS_RAMP2, 32'h02580000);
    ramp_contact_i <= 1'b1;
    settle();
    run_contact_i <= 1'b1;
    settle();
    chk(32'({ramp_set_o, ramp_time_o, ramp_ilim_o}), 32'h40258);
    chk(32'({motor_on_o, bypass_o, at_speed_o}), 32'h7);
    run_contact_i <= 1'b0;
    settle();
    chk(32'({motor_on_o, decel_active_o, bypass_o, aux_o}), 32'h30);
    jog_contact_i <= 1'b0;
    settle();
    chk(32'({fault_o, motor_on_o, trip_code_o}), 32'h4a);
    chk(32'(aux_o), relays(1, 10, 0, 0));
    jog_contact_i <= 1'b1;
    stop_en <= 1'b1;
    settle();
    bus(1'b1, sscs_pkg::OFS_CTRL, ctrl | 32'h4);
    run_contact_i <= 1'b1;
    settle();
    run_contact_i <= 1'b0;
    settle();
    chk(32'({motor_on_o, decel_active_o}), 32'h0);
    stop_en <= 1'b0;
    // Default inputs: lockout in run, cleared by the reset contact
    ctrl = 32'h0;
    bus(1'b1, sscs_pkg::OFS_CTRL, ctrl);
    ramp_contact_i <= 1'b0;
    run_contact_i <= 1'b1;
    settle();
    wait_speed();
    jog_contact_i <= 1'b0;
    settle();
    chk(32'({fault_o, trip_code_o}), 32'h29);
    run_contact_i <= 1'b0;
    jog_contact_i <= 1'b1;
    settle();
    ramp_contact_i <= 1'b1;
    settle();
    chk(32'({fault_o, trip_code_o}), 32'h0);
    ramp_contact_i <= 1'b0;
    jog_contact_i <= 1'b0;
    settle();
    chk(32'({fault_o, trip_code_o}), 32'h28);
    // Jog function with serial control following the jog contact
    ctrl = 32'h280;
    jog_contact_i <= 1'b1;
    bus(1'b1, sscs_pkg::OFS_CTRL, ctrl | 32'h4);
    settle();
    chk(32'({motor_on_o, jog_active_o, serial_ctrl_o}), 32'h1);
    bus(1'b1, sscs_pkg::OFS_CTRL, ctrl | 32'h2);
    tick(2);
    chk(32'({motor_on_o, jog_active_o}), 32'h3);
    bus(1'b1, sscs_pkg::OFS_CTRL, ctrl);
    jog_contact_i <= 1'b0;
    settle();
    chk(32'({motor_on_o, serial_ctrl_o}), 32'h0);
    // Normally-open lockout trips on closure
    bus(1'b1, sscs_pkg::OFS_CTRL, 32'h40);
    jog_contact_i <= 1'b1;
    settle();
    chk(32'({fault_o, trip_code_o}), 32'h28);
    ctrl = 32'h80;
    bus(1'b1, sscs_pkg::OFS_CTRL, ctrl | 32'h4);
    // Trip codes: boundaries and random, default then reprogrammed relays
    codes = '{4, 5, 21, 22};
    for (int i = 0; i < 4; i++) begin
      lfsr = next_lfsr(lfsr);
      codes.push_back(int'(lfsr % 31) + 1);
    end
    for (int r = 0; r < 2; r++) begin
      if (r == 1) begin
        fns = 32'h00000316;
        bus(1'b1, sscs_pkg::OFS_RELAY, fns);
        bus(1'b0, sscs_pkg::OFS_RELAY, 32'h0);
        chk(q, fns);
      end
      foreach (codes[i]) begin
        @(posedge clock_i);
        fault_code_i <= 5'(codes[i]);
        fault_valid_i <= 1'b1;
        @(posedge clock_i);
        fault_valid_i <= 1'b0;
        tick(3);
        chk(32'({fault_o, trip_code_o}), 32'(codes[i]) | 32'h20);
        chk(32'(aux_o), relays(1, codes[i], 0, 0));
        bus(1'b1, sscs_pkg::OFS_CTRL, ctrl | 32'h4);
        tick(2);
        chk(32'({fault_o, aux_o}), 32'h0);
      end
    end
    stop_test();
  end
endmodule
